// [src/pps_timing_host_serial_config.sv]
// Purpose: pulse-per-second generation, parameter store control, two serial ports
// Assumes: stored parameters presented on stored_params, written via store_* strobes
// Notes: commands arrive decoded as one-cycle pulses from the protocol engine
`include "pps_timing_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pps_timing_host_serial_config
	import pps_timing_pkg::*;
#(
	parameter int SECOND_CYCLES = `SECOND_CYCLES,
	parameter int PULSE_CYCLES = `PULSE_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic second_tick,
	input wire params_s stored_params,
	input wire logic stored_valid,
	input wire logic cfg_write,
	input wire params_s cfg_data,
	input wire cmd_s cmd,
	input wire logic port_a_receive,
	input wire logic port_b_receive,
	input wire logic [7:0] tx_a_data,
	input wire logic tx_a_valid,
	input wire logic [7:0] tx_b_data,
	input wire logic tx_b_valid,
	output logic pps_out,
	output logic report_req,
	output params_s active_params,
	output params_s store_data,
	output logic store_write,
	output logic store_ports_write,
	output logic store_pos_write,
	output logic store_pos_erase,
	output logic port_a_transmit,
	output logic port_b_transmit,
	output logic tx_a_ready,
	output logic tx_b_ready,
	output logic [7:0] rx_a_data,
	output logic rx_a_valid,
	output logic rx_a_error,
	output logic [7:0] rx_b_data,
	output logic rx_b_valid,
	output logic rx_b_error
);
	localparam int SEC_W = $clog2(SECOND_CYCLES + 1);

	// factory defaults for working parameters
	wire port_cfg_s def_a = '{divisor: 16'(`DIV_A_DEFAULT), data_bits: `DATA_BITS_DEFAULT,
		parity: PAR_NONE, stop_bits: `STOP_BITS_DEFAULT, proto: `PROTO_BINARY};
	wire port_cfg_s def_b = '{divisor: 16'(`DIV_B_DEFAULT), data_bits: `DATA_BITS_DEFAULT,
		parity: PAR_NONE, stop_bits: `STOP_BITS_DEFAULT, proto: `PROTO_NONE};
	wire params_s factory_params = '{cable_delay_ns: 32'sh0, rising_on_time: 1'b1,
		port_a: def_a, port_b: def_b};

	// load from storage once after reset release, or factory defaults when stored_valid is low
	logic loaded;
	logic [1:0] tick_sync;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			loaded <= 1'b0;
			active_params <= '0;
		end else if (!loaded) begin
			active_params <= stored_valid ? stored_params : factory_params;
			loaded <= 1'b1;
		end else if (cmd.factory) begin
			active_params <= factory_params;
		end else if (cfg_write) begin
			active_params <= cfg_data;
		end
	end

	// storage strobes: only on explicit command
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			store_write <= 1'b0;
			store_ports_write <= 1'b0;
			store_pos_write <= 1'b0;
			store_pos_erase <= 1'b0;
			store_data <= '0;
		end else begin
			store_write <= loaded && (cmd.save_all || cmd.factory);
			store_ports_write <= loaded && cmd.save_ports;
			store_pos_write <= loaded && cmd.save_pos && !cmd.factory;
			store_pos_erase <= loaded && (cmd.delete_pos || cmd.factory);
			store_data <= cmd.factory ? factory_params : active_params;
		end
	end

	// second tick from the time base, synchronised
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) tick_sync <= 2'b00;
		else tick_sync <= {tick_sync[0], second_tick};
	end
	logic tick_last;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) tick_last <= 1'b0;
		else tick_last <= tick_sync[1];
	end
	wire tick_rise = tick_sync[1] && !tick_last;

	// offset in cycles; negative fires earlier, wrapped into the second
	wire signed [31:0] delay_cyc = active_params.cable_delay_ns / `DELAY_NS_PER_CYCLE;
	wire signed [32:0] fire_raw = (delay_cyc < 0) ? 33'(SECOND_CYCLES) + 33'(delay_cyc) : 33'(delay_cyc);
	wire [SEC_W-1:0] fire_at = SEC_W'(fire_raw);

	logic [SEC_W-1:0] sec_cnt;
	logic [SEC_W-1:0] pulse_cnt;
	logic pulse_on;
	wire fire = loaded && (sec_cnt == fire_at);
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) sec_cnt <= '0;
		else if (tick_rise) sec_cnt <= '0;
		else if (sec_cnt != SEC_W'(SECOND_CYCLES - 1)) sec_cnt <= sec_cnt + 1'b1;
		else sec_cnt <= '0;
	end
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pulse_on <= 1'b0;
			pulse_cnt <= '0;
		end else if (fire) begin
			pulse_on <= 1'b1;
			pulse_cnt <= '0;
		end else if (pulse_on && pulse_cnt == SEC_W'(PULSE_CYCLES - 1)) begin
			pulse_on <= 1'b0;
		end else if (pulse_on) begin
			pulse_cnt <= pulse_cnt + 1'b1;
		end
	end
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pps_out <= 1'b0;
			report_req <= 1'b0;
		end else begin
			pps_out <= loaded && (pulse_on ~^ active_params.rising_on_time);
			report_req <= pulse_on && pulse_cnt == SEC_W'(PULSE_CYCLES - 1);
		end
	end

	// two uart channels, no flow control
	wire port_cfg_s cfg [2] = '{active_params.port_a, active_params.port_b};
	wire rx_pin [2] = '{port_a_receive, port_b_receive};
	wire [7:0] txd [2] = '{tx_a_data, tx_b_data};
	wire txv [2] = '{tx_a_valid, tx_b_valid};
	logic tx_pin [2];
	logic tx_rdy [2];
	logic [7:0] rxd [2];
	logic rxv [2];
	logic rxe [2];
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : ch
			logic [1:0] rs;
			logic [15:0] tdiv, rdiv;
			logic [11:0] tsh;
			logic [3:0] tleft, rleft;
			logic tbusy, rbusy;
			logic [10:0] rsh;
			wire [3:0] nbits = cfg[g].data_bits;
			wire par_en = cfg[g].parity != PAR_NONE;
			wire [7:0] tmask = txd[g] & 8'(9'h1FF >> (4'h9 - nbits));
			wire tpar = ^tmask ^ (cfg[g].parity == PAR_ODD);
			wire [3:0] tbits = 4'(1 + nbits + par_en + cfg[g].stop_bits);
			wire take = tx_rdy[g] && txv[g];
			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) rs <= 2'b11;
				else rs <= {rs[0], rx_pin[g]};
			end
			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					tbusy <= 1'b0;
					tsh <= 12'hFFF;
					tdiv <= '0;
					tleft <= '0;
				end else if (take) begin
					// start, data lsb first, parity, stops
					tsh <= ((12'hFFF << (nbits + par_en + 1)) | (12'(tpar & par_en) << (nbits + 1))
						| (12'(tmask) << 1));
					tbusy <= 1'b1;
					tleft <= tbits;
					tdiv <= cfg[g].divisor;
				end else if (tbusy) begin
					if (tdiv == 16'h1) begin
						tdiv <= cfg[g].divisor;
						tsh <= {1'b1, tsh[11:1]};
						tleft <= tleft - 4'h1;
						if (tleft == 4'h1) tbusy <= 1'b0;
					end else begin
						tdiv <= tdiv - 16'h1;
					end
				end
			end
			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					tx_pin[g] <= 1'b1;
					tx_rdy[g] <= 1'b0;
				end else begin
					tx_pin[g] <= tbusy ? tsh[0] : 1'b1;
					tx_rdy[g] <= loaded && !tbusy && !take;
				end
			end
			wire [7:0] rmask = 8'(9'h1FF >> (4'h9 - nbits));
			wire [7:0] rdata = 8'(rsh >> (4'hB - nbits - par_en)) & rmask;
			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					rbusy <= 1'b0;
					rdiv <= '0;
					rleft <= '0;
					rsh <= '0;
					rxd[g] <= '0;
					rxv[g] <= 1'b0;
					rxe[g] <= 1'b0;
				end else begin
					rxv[g] <= 1'b0;
					rxe[g] <= 1'b0;
					if (!rbusy && !rs[1]) begin
						rbusy <= 1'b1;
						rdiv <= {1'b0, cfg[g].divisor[15:1]};
						rleft <= 4'(1 + nbits + par_en);
					end else if (rbusy) begin
						if (rdiv == 16'h0) begin
							rdiv <= cfg[g].divisor - 16'h1;
							rsh <= {rs[1], rsh[10:1]};
							if (rleft == 4'h0) begin
								rbusy <= 1'b0;
								rxd[g] <= rdata;
								rxv[g] <= rs[1];
								rxe[g] <= !rs[1] || (par_en && (^(rsh >> (4'hA - nbits)) ^ (cfg[g].parity == PAR_ODD)));
							end
							rleft <= rleft - 4'h1;
						end else begin
							rdiv <= rdiv - 16'h1;
						end
					end
				end
			end
		end
	endgenerate
	assign port_a_transmit = tx_pin[0];
	assign port_b_transmit = tx_pin[1];
	assign tx_a_ready = tx_rdy[0];
	assign tx_b_ready = tx_rdy[1];
	assign rx_a_data = rxd[0];
	assign rx_b_data = rxd[1];
	assign rx_a_valid = rxv[0];
	assign rx_b_valid = rxv[1];
	assign rx_a_error = rxe[0];
	assign rx_b_error = rxe[1];

	pulse_len_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(pulse_on) |-> pulse_on [*8])
		else $error("pulse too short");
	fire_phase_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(pulse_on) |-> $past(loaded && sec_cnt == fire_at))
		else $error("pulse off its offset");
	edge_pol_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		pulse_on && loaded |-> ##1 (pps_out == $past(active_params.rising_on_time)))
		else $error("edge polarity");
	pps_idle_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		loaded && !pulse_on |=> pps_out == !$past(active_params.rising_on_time))
		else $error("idle level");
	report_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		report_req |-> $past(pulse_on))
		else $error("report without pulse");
	pulse_end_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		$fell(pulse_on) |-> report_req)
		else $error("pulse ended without report");
	report_once_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		report_req |=> !report_req)
		else $error("report longer than one cycle");
	cfg_apply_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		loaded && cfg_write && !cmd.factory |=> active_params == $past(cfg_data))
		else $error("config late");
	cfg_no_save_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		loaded && cfg_write && !cmd.save_all && !cmd.factory |=> !store_write)
		else $error("config saved without command");
	load_once_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		!loaded |=> loaded && active_params == $past(stored_valid ? stored_params : factory_params))
		else $error("parameters not loaded");
	no_auto_save_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		store_write |-> $past(cmd.save_all || cmd.factory))
		else $error("unrequested save");
	save_data_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		loaded && cmd.save_all && !cmd.factory |=> store_write && store_data == $past(active_params))
		else $error("save data");
	factory_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		loaded && cmd.factory |=> store_pos_erase && active_params == factory_params)
		else $error("factory");
	pos_erase_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		store_pos_erase |-> $past(cmd.delete_pos || cmd.factory))
		else $error("unrequested position erase");
	port_save_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		loaded && cmd.save_ports |=> store_ports_write)
		else $error("port save");
	tx_take_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		tx_a_ready && tx_a_valid |=> !tx_a_ready && ch[0].tbusy)
		else $error("byte not taken");
	tx_idle_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		!ch[0].tbusy ##1 !ch[0].tbusy |-> port_a_transmit)
		else $error("line not idle high");
	rx_once_a: assert property (@(posedge clk_sys) disable iff (!rstn)
		rx_a_valid |=> !rx_a_valid)
		else $error("receive valid longer than one cycle");
endmodule : pps_timing_host_serial_config
`default_nettype wire

// [src/pps_timing_params.svh]
// Purpose: constants for the pps timing and serial configuration block
// Assumes: 200 MHz system clock
// Notes: timing counts derive from times in their own units
// Contract
// - pulse shifted by signed cable delay offset; negative moves it earlier
// - cable delay accepted by configuration command and savable to storage
// - leading edge aligned to second; rising or falling chosen by configuration
// - timing report request issued after each pulse
// - position time stamp marks that fix only, not the pulse
// - new configuration applies at once; storage only on command
// - on reset operating parameters load from stored values
// - save command writes all current parameters to storage
// - factory request restores defaults and erases stored position
// - stored reference position saved or deleted on command
// - port settings live in working storage; saved on port command
// - port a defaults binary both ways, 115 kbps, 8N1
// - port b defaults 921 kbps, no protocol; set via port a
// - host may change baud, data bits, parity and stop bits
// - no flow control on either port
// - nmea input only proprietary; nmea output and binary both ways
`ifndef PPS_TIMING_PARAMS_SVH
`define PPS_TIMING_PARAMS_SVH
`define CLK_HZ 200000000
`define SECOND_CYCLES 200000000
`define DELAY_NS_PER_CYCLE 5
`define BAUD_A_DEFAULT 115200
`define BAUD_B_DEFAULT 921600
`define DIV_A_DEFAULT (`CLK_HZ / `BAUD_A_DEFAULT)
`define DIV_B_DEFAULT (`CLK_HZ / `BAUD_B_DEFAULT)
`define DATA_BITS_DEFAULT 4'h8
`define STOP_BITS_DEFAULT 2'h1
`define PULSE_NS 100000
`define PULSE_CYCLES (`PULSE_NS / `DELAY_NS_PER_CYCLE)
`define PROTO_NONE 2'h0
`define PROTO_BINARY 2'h1
`define PROTO_NMEA 2'h2
`endif

// [src/pps_timing_pkg.sv]
// Purpose: shared types for the pps timing block
// Assumes: nothing
// Notes: port configuration carried as one struct
package pps_timing_pkg;
	typedef enum logic [1:0] {PAR_NONE = 2'h0, PAR_ODD = 2'h1, PAR_EVEN = 2'h2} parity_e;
	typedef struct packed {
		logic [15:0] divisor;
		logic [3:0] data_bits;
		parity_e parity;
		logic [1:0] stop_bits;
		logic [1:0] proto;
	} port_cfg_s;
	typedef struct packed {
		logic signed [31:0] cable_delay_ns;
		logic rising_on_time;
		port_cfg_s port_a;
		port_cfg_s port_b;
	} params_s;
	typedef struct packed {
		logic save_all;
		logic factory;
		logic save_ports;
		logic save_pos;
		logic delete_pos;
	} cmd_s;
endpackage : pps_timing_pkg

// [test/host_serial_model.sv]
// Purpose: host side of one serial port
// Assumes: div clock cycles per bit, line idle high
// Notes: sends with chosen parity and stop level, receives 8N1, never throttles
`timescale 1ns/1ps
`default_nettype none
module host_serial_model
	import pps_timing_pkg::*;
(
	input wire logic clk_sys,
	input wire logic [15:0] div,
	input wire logic line_in,
	output logic line_out,
	output logic [7:0] got,
	output logic got_stop
);
	initial line_out = 1'b1;
	task automatic send(input logic [7:0] d, input parity_e par, input logic stop);
		logic [10:0] f;
		f = (par == PAR_NONE) ? {1'b1, stop, d, 1'b0} : {stop, (par == PAR_ODD) ? ~^d : ^d, d, 1'b0};
		for (int i = 0; i < ((par == PAR_NONE) ? 10 : 11); i++) begin
			line_out = f[i];
			repeat (div) @(posedge clk_sys);
			#1;
		end
		line_out = 1'b1;
	endtask : send
	// samples mid-bit after the start edge
	always begin
		@(negedge line_in);
		repeat (div / 2) @(posedge clk_sys);
		for (int i = 0; i < 9; i++) begin
			repeat (div) @(posedge clk_sys);
			if (i < 8) got[i] = line_in;
			else got_stop = line_in;
		end
	end
endmodule : host_serial_model
`default_nettype wire

// [test/tb_top.sv]
// Purpose: self-checking bench for the pps timing and serial block
// Assumes: 200 MHz clock, second shortened to 1000 cycles
// Notes: host models sit on both serial ports
`include "pps_timing_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import pps_timing_pkg::*;
;
	localparam port_cfg_s def_a = '{16'(`DIV_A_DEFAULT), `DATA_BITS_DEFAULT, PAR_NONE, `STOP_BITS_DEFAULT, `PROTO_BINARY};
	localparam port_cfg_s def_b = '{16'(`DIV_B_DEFAULT), `DATA_BITS_DEFAULT, PAR_NONE, `STOP_BITS_DEFAULT, `PROTO_NONE};
	logic clk_sys = 1'b0, rstn = 1'b0, second_tick = 1'b0, stored_valid = 1'b0, cfg_write = 1'b0;
	logic port_a_receive, port_b_receive, tx_a_valid = 1'b0, tx_b_valid = 1'b0, pps_out, report_req;
	logic store_write, store_ports_write, store_pos_write, store_pos_erase, port_a_transmit, port_b_transmit;
	logic tx_a_ready, tx_b_ready, rx_a_valid, rx_a_error, rx_b_valid, rx_b_error, stop_a, stop_b;
	logic [7:0] tx_a_data = 8'h00, tx_b_data = 8'h00, rx_a_data, rx_b_data, got_a, got_b;
	// command in the upper five bits, expected strobes below
	logic [8:0] rows [5] = '{9'h108, 9'h044, 9'h022, 9'h011, 9'h089};
	params_s stored_params = '0, cfg_data = '0, active_params, store_data;
	cmd_s cmd = '0;
	int cyc = 0, n_fail = 0, check_count = 0, p0;
	pps_timing_host_serial_config #(.SECOND_CYCLES(1000), .PULSE_CYCLES(10)) DUT (.clk_sys, .rstn, .second_tick,
		.stored_params, .stored_valid, .cfg_write, .cfg_data, .cmd, .port_a_receive, .port_b_receive, .tx_a_data,
		.tx_a_valid, .tx_b_data, .tx_b_valid, .pps_out, .report_req, .active_params, .store_data, .store_write,
		.store_ports_write, .store_pos_write, .store_pos_erase, .port_a_transmit, .port_b_transmit, .tx_a_ready,
		.tx_b_ready, .rx_a_data, .rx_a_valid, .rx_a_error, .rx_b_data, .rx_b_valid, .rx_b_error);
	host_serial_model ha (.clk_sys, .div(16'h0010), .line_in(port_a_transmit), .line_out(port_a_receive),
		.got(got_a), .got_stop(stop_a));
	host_serial_model hb (.clk_sys, .div(16'h0008), .line_in(port_b_transmit), .line_out(port_b_receive),
		.got(got_b), .got_stop(stop_b));
	always #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		second_tick <= #1 ((cyc % 1000) < 500);
		if (cyc == 40000) begin
			n_fail++;
			stop_test;
		end
	end
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : stop_test
	task automatic check(input logic [127:0] s, input logic [127:0] e);
		check_count++;
		if (s !== e) begin
			n_fail++;
			$display("FAIL %0t seen %0h expected %0h", $time, s, e);
		end
	endtask : check
	task automatic step;
		@(posedge clk_sys);
		#1;
	endtask : step
	function automatic params_s mk(input logic signed [31:0] dly, input logic rise, input parity_e pa);
		mk = '{dly, rise, '{16'h0010, 4'h8, pa, 2'h1, `PROTO_BINARY}, '{16'h0008, 4'h8, PAR_NONE, 2'h1, `PROTO_NMEA}};
	endfunction : mk
	task automatic put(input params_s p);
		cfg_data = p;
		cfg_write = 1'b1;
		step;
		cfg_write = 1'b0;
		check(active_params, p);
		check(store_write, 1'b0);
		step;
	endtask : put
	task automatic pulse(input logic act, output int ph);
		int n;
		int w;
		logic r;
		r = 1'b0;
		for (n = 0; pps_out === act && n < 3000; n++) step;
		for (n = 0; pps_out !== act && n < 3000; n++) step;
		ph = cyc % 1000;
		for (w = 0; pps_out === act && w < 50; w++) begin
			r |= report_req;
			step;
		end
		repeat (3) begin
			r |= report_req;
			step;
		end
		check(w, 10);
		check(r, 1'b1);
	endtask : pulse
	task automatic sec(input params_s p, input int e);
		int ph;
		put(p);
		repeat (2) pulse(p.rising_on_time, ph);
		check(ph, e % 1000);
	endtask : sec
	task automatic frame(input logic b, input logic [7:0] d, input parity_e p, input logic s, input logic e);
		int n;
		fork
			if (b) hb.send(d, p, s);
			else ha.send(d, p, s);
			begin
				for (n = 0; (b ? rx_b_valid | rx_b_error : rx_a_valid | rx_a_error) !== 1'b1 && n < 400; n++) step;
				check(b ? rx_b_error : rx_a_error, e);
				if (!e) check(b ? rx_b_data : rx_a_data, d);
			end
		join
		repeat (20) step;
	endtask : frame
	task automatic send_tx(input logic b, input logic [7:0] d);
		int n;
		tx_a_data = d;
		tx_b_data = d;
		tx_a_valid = !b;
		tx_b_valid = b;
		for (n = 0; (b ? tx_b_ready : tx_a_ready) !== 1'b1 && n < 400; n++) step;
		step;
		tx_a_valid = 1'b0;
		tx_b_valid = 1'b0;
		check(b ? tx_b_ready : tx_a_ready, 1'b0);
		repeat (200) step;
		check(b ? got_b : got_a, d);
		check(b ? stop_b : stop_a, 1'b1);
	endtask : send_tx
	initial begin
		repeat (3) step;
		check(port_a_transmit, 1'b1);
		check(port_b_transmit, 1'b1);
		check(pps_out, 1'b0);
		rstn = 1'b1;
		repeat (2) step;
		check(active_params.port_a, def_a);
		check(active_params.port_b, def_b);
		rstn = 1'b0;
		stored_params = mk(0, 1'b1, PAR_NONE);
		stored_valid = 1'b1;
		repeat (2) step;
		rstn = 1'b1;
		repeat (2) step;
		check(active_params, stored_params);
		frame(1'b0, 8'hA5, PAR_NONE, 1'b1, 1'b0);
		frame(1'b1, 8'h3C, PAR_NONE, 1'b1, 1'b0);
		frame(1'b0, 8'h5A, PAR_NONE, 1'b0, 1'b1);
		send_tx(1'b0, 8'hC3);
		send_tx(1'b1, 8'h96);
		put(mk(0, 1'b1, PAR_EVEN));
		frame(1'b0, 8'h07, PAR_EVEN, 1'b1, 1'b0);
		frame(1'b0, 8'h07, PAR_ODD, 1'b1, 1'b1);
		put(mk(0, 1'b1, PAR_NONE));
		repeat (2) pulse(1'b1, p0);
		sec(mk(100, 1'b1, PAR_NONE), p0 + 20);
		sec(mk(0, 1'b0, PAR_NONE), p0);
		sec(mk(-100, 1'b1, PAR_NONE), p0 + 980);
		for (int i = 0; i < 5; i++) begin
			cmd = rows[i][8:4];
			step;
			cmd = '0;
			check({store_write, store_ports_write, store_pos_write, store_pos_erase}, rows[i][3:0]);
			if (i == 0) check(store_data, mk(-100, 1'b1, PAR_NONE));
			step;
			check({store_write, store_ports_write, store_pos_write, store_pos_erase}, 4'h0);
		end
		check(active_params.port_a, def_a);
		check(active_params.port_b, def_b);
		stop_test;
	end
endmodule : tb_top
`default_nettype wire
